//--- dual_8bit_timer_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_8bit_timer_control_test;
  // Table row: channel, config, clock code, period, expected toggle spacing
  typedef struct packed {
    logic        ch;
    logic [1:0]  cfg;
    logic [2:0]  code;
    logic [7:0]  per;
    logic [15:0] gap;
  } row_t;

  logic                clock_i;
  logic                rst_i;
  timer_pkg::reg_req_t req;
  logic [7:0]          rdata;
  logic                low_clk;
  logic                pin3;
  logic                pin4;
  logic                out3;
  logic                out4;
  logic                irq;
  int                  src_cnt;
  int                  fails;
  int                  tests_run;
  int                  n;
  row_t                rows [20];
  logic [7:0]          wv [10];
  logic [7:0]          ev [10];

  dual_timer_control dut (
    .clock_i          (clock_i),
    .rst_i            (rst_i),
    .req_i            (req),
    .rdata_o          (rdata),
    .low_freq_clock_i (low_clk),
    .timer3_pin_i     (pin3),
    .timer4_pin_i     (pin4),
    .timer3_out_o     (out3),
    .timer4_out_o     (out4),
    .irq_o            (irq)
  );

  // Clock
  always #12.5 clock_i = ~clock_i;

  // Low clock every 10 cycles, pins every 12 cycles
  always @(posedge clock_i) begin
    src_cnt <= src_cnt + 1;
    if (src_cnt % 5 == 4) low_clk <= ~low_clk;
    if (src_cnt % 6 == 5) begin
      pin3 <= ~pin3;
      pin4 <= ~pin4;
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] expd, input string what);
    tests_run++;
    if (seen !== expd) begin
      fails++;
      $display("MISMATCH t=%0t %s seen %0h expected %0h", $time, what, seen, expd);
    end
  endtask : check

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clock_i);
    req.wr    <= 1'b0;
  endtask : wr

  // Read strobe, data taken in the following cycle
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clock_i);
    req.rd   <= 1'b0;
    #1;
    check(32'(rdata), 32'(e), "read data");
  endtask : rdchk

  function automatic logic [7:0] mk(input logic i, input logic [2:0] c, input logic r,
                                    input logic [2:0] m);
    return {i, c, r, m};
  endfunction : mk

  function automatic logic out_of(input logic ch4);
    return ch4 ? out4 : out3;
  endfunction : out_of

  // Cycles between two output toggles; 0 when none seen
  task automatic interval(input logic ch4, input int limit, output int gap);
    logic last;
    int   k;
    // Let the start load of the flip-flop pass first
    repeat (2) @(posedge clock_i);
    #1;
    last = out_of(ch4);
    k = 0;
    while (out_of(ch4) === last && k < limit) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    last = out_of(ch4);
    gap = 0;
    while (gap < limit) begin
      @(posedge clock_i);
      #1;
      gap++;
      if (out_of(ch4) !== last) break;
    end
    if (k >= limit) gap = 0;
  endtask : interval

  // Watchdog
  initial begin
    #2500000;
    fails++;
    end_of_test();
  end

  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    req = '0;
    low_clk = 1'b0;
    pin3 = 1'b0;
    pin4 = 1'b1;
    src_cnt = 0;
    fails = 0;
    tests_run = 0;
    rows = '{'{0,0,3'h6,8'h04,16'h0005}, '{1,0,3'h6,8'h04,16'h0005},
             '{0,0,3'h1,8'h00,16'h0080}, '{0,0,3'h2,8'h00,16'h0020},
             '{0,0,3'h3,8'h00,16'h0008}, '{0,0,3'h5,8'h00,16'h0002},
             '{0,0,3'h6,8'h00,16'h0001}, '{0,0,3'h4,8'h00,16'h000A},
             '{0,0,3'h7,8'h00,16'h000C}, '{0,0,3'h0,8'h00,16'h0800},
             '{0,1,3'h0,8'h00,16'h0050}, '{0,2,3'h0,8'h00,16'h0050},
             '{0,2,3'h4,8'h00,16'h000A}, '{0,2,3'h6,8'h00,16'h0001},
             '{0,2,3'h3,8'h00,16'h0000}, '{0,2,3'h7,8'h00,16'h0000},
             '{0,2,3'h1,8'h00,16'h0000}, '{1,0,3'h7,8'h00,16'h000C},
             '{1,0,3'h3,8'h00,16'h0008}, '{1,2,3'h2,8'h00,16'h0000}};
    wv = '{8'hA5, 8'h5A, 8'h3C, 8'hE6, 8'hC3, 8'h96, 8'hFF, 8'h00, 8'hFF, 8'hFF};
    ev = '{8'hA5, 8'h5A, 8'h3C, 8'hE6, 8'hC3, 8'h96, 8'h03, 8'h00, 8'h03, 8'h00};
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    check(32'({out3, out4, irq, rdata}), 32'h0, "outputs after reset");
    for (int i = 0; i < 10; i++) rdchk(i[3:0], 8'h00);
    // Write every index except 7, read all back; index 9 is unmapped
    // Pulse width written only while stopped
    for (int i = 0; i < 10; i++) if (i != 7) wr(i[3:0], wv[i]);
    for (int i = 0; i < 10; i++) rdchk(i[3:0], ev[i]);
    @(posedge clock_i);
    #1;
    check(32'(rdata), 32'h0, "read data held too long");
    // Back-to-back write then read of one register
    @(posedge clock_i);
    req.addr  <= timer_pkg::ADDR_T4_PW;
    req.wdata <= 8'h69;
    req.wr    <= 1'b1;
    @(posedge clock_i);
    req.wr    <= 1'b0;
    req.rd    <= 1'b1;
    @(posedge clock_i);
    req.rd    <= 1'b0;
    #1;
    check(32'(rdata), 32'h69, "back-to-back readback");
    for (int i = 0; i < 9; i++) if (i != 7) wr(i[3:0], 8'h00);
    // Clock sources and periods; period set while stopped
    foreach (rows[j]) begin
      wr(timer_pkg::ADDR_CONFIG, {6'h00, rows[j].cfg});
      wr(rows[j].ch ? timer_pkg::ADDR_T4_PERIOD : timer_pkg::ADDR_T3_PERIOD, rows[j].per);
      wr(rows[j].ch ? timer_pkg::ADDR_T4_CONTROL : timer_pkg::ADDR_T3_CONTROL,
         mk(0, rows[j].code, 1, timer_pkg::MODE_TIMER));
      interval(rows[j].ch, 2500, n);
      check(32'(n), {16'h0000, rows[j].gap}, "toggle spacing");
      wr(rows[j].ch ? timer_pkg::ADDR_T4_CONTROL : timer_pkg::ADDR_T3_CONTROL,
         mk(0, rows[j].code, 0, timer_pkg::MODE_TIMER));
    end
    wr(timer_pkg::ADDR_CONFIG, 8'h00);
    #1;
    // Sticky status, clear on read, mask
    check(32'(irq), 32'h0, "masked irq");
    rdchk(timer_pkg::ADDR_STATUS, 8'h03);
    rdchk(timer_pkg::ADDR_STATUS, 8'h00);
    wr(timer_pkg::ADDR_MASK, 8'h01);
    wr(timer_pkg::ADDR_T3_PERIOD, 8'h04);
    wr(timer_pkg::ADDR_T3_CONTROL, mk(0, 3'h6, 1, 3'h0));
    repeat (12) @(posedge clock_i);
    wr(timer_pkg::ADDR_T3_CONTROL, mk(0, 3'h6, 0, 3'h0));
    interval(0, 60, n);
    check(32'(n), 32'h0, "stopped channel toggled");
    check(32'(irq), 32'h1, "irq not raised");
    rdchk(timer_pkg::ADDR_STATUS, 8'h01);
    repeat (2) @(posedge clock_i);
    #1;
    check(32'(irq), 32'h0, "irq not cleared");
    wr(timer_pkg::ADDR_T4_PERIOD, 8'h04);
    wr(timer_pkg::ADDR_T4_CONTROL, mk(0, 3'h6, 1, 3'h0));
    repeat (12) @(posedge clock_i);
    wr(timer_pkg::ADDR_T4_CONTROL, mk(0, 3'h6, 0, 3'h0));
    #1;
    check(32'(irq), 32'h0, "irq not masked");
    rdchk(timer_pkg::ADDR_STATUS, 8'h02);
    // Read against a match in the same cycle: the match wins
    wr(timer_pkg::ADDR_T4_PERIOD, 8'h00);
    wr(timer_pkg::ADDR_T4_CONTROL, mk(0, 3'h6, 1, 3'h0));
    rdchk(timer_pkg::ADDR_STATUS, 8'h02);
    rdchk(timer_pkg::ADDR_STATUS, 8'h02);
    wr(timer_pkg::ADDR_T4_CONTROL, mk(0, 3'h6, 0, 3'h0));
    // Start write also loads flip-flop level
    wr(timer_pkg::ADDR_T3_PERIOD, 8'hFF);
    for (int i = 1; i >= 0; i--) begin
      wr(timer_pkg::ADDR_T3_CONTROL, mk(i[0], 3'h6, 1, 3'h0));
      repeat (3) @(posedge clock_i);
      #1;
      check(32'(out3), 32'(i[0]), "flip-flop start level");
      wr(timer_pkg::ADDR_T3_CONTROL, mk(i[0], 3'h6, 0, 3'h0));
    end
    // Reserved channel 3 mode does not count
    wr(timer_pkg::ADDR_T3_PERIOD, 8'h00);
    wr(timer_pkg::ADDR_T3_CONTROL, mk(0, 3'h6, 1, 3'h4));
    interval(0, 60, n);
    check(32'(n), 32'h0, "reserved mode counted");
    wr(timer_pkg::ADDR_T3_CONTROL, mk(0, 3'h6, 0, 3'h4));
    // Cascade: channel 3 clock, channel 4 run and level, pin ignored
    wr(timer_pkg::ADDR_T4_PERIOD, 8'h01);
    wr(timer_pkg::ADDR_T3_CONTROL, mk(0, 3'h6, 0, timer_pkg::MODE_CASCADE));
    for (int m = 4; m < 8; m++) begin
      wr(timer_pkg::ADDR_T4_CONTROL, mk(m[0], 3'h7, 1, m[2:0]));
      repeat (3) @(posedge clock_i);
      #1;
      check(32'(out4), 32'(m[0]), "cascade start level");
      check(32'(out3), 32'(m[0]), "cascade channel 3 level");
      interval(1, 600, n);
      check(32'(n), 32'd257, "cascade spacing");
      wr(timer_pkg::ADDR_T4_CONTROL, mk(m[0], 3'h7, 0, m[2:0]));
    end
    // Reset in mid-run
    wr(timer_pkg::ADDR_T4_CONTROL, mk(1, 3'h6, 1, 3'h4));
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    check(32'({out3, out4, irq}), 32'h0, "outputs after second reset");
    rdchk(timer_pkg::ADDR_T4_CONTROL, 8'h00);
    end_of_test();
  end
endmodule : dual_8bit_timer_control_test
`default_nettype wire

//--- dual_timer_control.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: Channel 3 has control, period, pulse-width registers
// RQ2: Software leaves channel 3 period alone running
// RQ3: Channel 3 pulse width changes only PWM
// RQ4: Clock code selects divided high/low/pin source
// RQ5: Slow mode allows only codes 000,100,110
// RQ6: Run 0 stops and clears; 1 starts
// RQ7: Channel 3 mode selects; top-bit codes reserved
// RQ8: Cascade needs channel 3 mode 011
// RQ9: Cascade: ch3 clock, ch4 run and flip-flop
// RQ10: No control changes while channel runs
// RQ11: Stop write keeps other control fields
// RQ12: Start write may set mode, clock, level
// RQ13: Software picks clocks allowed for mode
// RQ14: Channel 4 mirrors channel 3 registers
// RQ15: Software leaves channel 4 period alone running
// RQ16: Channel 4 pulse width changes only PWM
// RQ17: Channel 4 top-bit codes are cascaded modes
// RQ18: Cascaded channel 4 counts channel 3 overflow
// RQ19: Pin source synchronised, counted on rising edge
module dual_timer_control (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // Register port
  input  wire timer_pkg::reg_req_t  req_i,
  output logic [7:0]                rdata_o,
  // Pins
  input  wire logic                 low_freq_clock_i,
  input  wire logic                 timer3_pin_i,
  input  wire logic                 timer4_pin_i,
  // Timer outputs and interrupt
  output logic                      timer3_out_o,
  output logic                      timer4_out_o,
  output logic                      irq_o
);

  timer_pkg::timer_state_t r_r;
  timer_pkg::timer_state_t r_nxt;

  logic cascade;
  logic cas4;
  logic wide16;
  logic run3;
  logic run4;
  logic ff3_init;
  logic tick3;
  logic tick4;
  logic step4;
  logic ovf3;
  logic match3;
  logic match4;
  logic match16;
  logic status_read;

  // Write decode for one register
  function automatic logic wr_hit(input timer_pkg::reg_req_t q, input logic [3:0] a);
    return q.wr && (q.addr == a);
  endfunction : wr_hit

  // Cascade decode and effective run/init selection
  assign cascade  = r_r.t3_ctl.mode_select == timer_pkg::MODE_CASCADE; // [RQ8]
  assign cas4     = r_r.t4_ctl.mode_select[2]; // [RQ17]
  assign wide16   = cascade && cas4;
  assign run3     = cascade ? r_r.t4_ctl.run
                            : (r_r.t3_ctl.run && !r_r.t3_ctl.mode_select[2]); // [RQ9] [RQ7]
  assign ff3_init = cascade ? r_r.t4_ctl.flipflop_init : r_r.t3_ctl.flipflop_init; // [RQ9]
  assign run4     = r_r.t4_ctl.run && (!cas4 || cascade);

  // Source selectors, channel 3 clock also drives the 16-bit pair
  tick_source u_src3 (
    .clock_i                    (clock_i),
    .rst_i                      (rst_i),
    .clock_select_i             (r_r.t3_ctl.clock_select), // [RQ9]
    .slow_mode_i                (r_r.config_bits[timer_pkg::CFG_SLOW_MODE]),
    .divider_low_clock_option_i (r_r.config_bits[timer_pkg::CFG_DIVIDER_OPT]),
    .low_freq_clock_i           (r_r.sync_low[1]),
    .ext_pin_i                  (r_r.sync_pin3[1]),
    .tick_o                     (tick3)
  );

  tick_source u_src4 (
    .clock_i                    (clock_i),
    .rst_i                      (rst_i),
    .clock_select_i             (r_r.t4_ctl.clock_select),
    .slow_mode_i                (r_r.config_bits[timer_pkg::CFG_SLOW_MODE]),
    .divider_low_clock_option_i (r_r.config_bits[timer_pkg::CFG_DIVIDER_OPT]),
    .low_freq_clock_i           (r_r.sync_low[1]),
    .ext_pin_i                  (r_r.sync_pin4[1]),
    .tick_o                     (tick4)
  );

  // Count events
  assign ovf3    = run3 && tick3 && (r_r.cnt3 == 8'hFF);
  assign match16 = wide16 && run3 && tick3
                   && ({r_r.cnt4, r_r.cnt3} == {r_r.t4_period, r_r.t3_period});
  assign match3  = !cascade && run3 && tick3 && (r_r.cnt3 == r_r.t3_period);
  assign step4   = cas4 ? ovf3 : tick4; // [RQ18]
  assign match4  = match16 || (!cas4 && run4 && step4 && (r_r.cnt4 == r_r.t4_period));
  assign status_read = req_i.rd && (req_i.addr == timer_pkg::ADDR_STATUS);

  // Next-state logic
  always_comb begin
    r_nxt = r_r;

    // Two-flop synchronisers for pins
    r_nxt.sync_low  = {r_r.sync_low[0], low_freq_clock_i};
    r_nxt.sync_pin3 = {r_r.sync_pin3[0], timer3_pin_i}; // [RQ19]
    r_nxt.sync_pin4 = {r_r.sync_pin4[0], timer4_pin_i};

    // Register writes; start write takes all fields at once
    if (wr_hit(req_i, timer_pkg::ADDR_T3_CONTROL)) begin
      r_nxt.t3_ctl = timer_pkg::control_t'(req_i.wdata); // [RQ1] [RQ12]
    end
    if (wr_hit(req_i, timer_pkg::ADDR_T3_PERIOD)) begin
      r_nxt.t3_period = req_i.wdata; // [RQ1]
    end
    if (wr_hit(req_i, timer_pkg::ADDR_T3_PW)) begin
      r_nxt.t3_pw = req_i.wdata; // [RQ1]
    end
    if (wr_hit(req_i, timer_pkg::ADDR_T4_CONTROL)) begin
      r_nxt.t4_ctl = timer_pkg::control_t'(req_i.wdata); // [RQ14] [RQ12]
    end
    if (wr_hit(req_i, timer_pkg::ADDR_T4_PERIOD)) begin
      r_nxt.t4_period = req_i.wdata; // [RQ14]
    end
    if (wr_hit(req_i, timer_pkg::ADDR_T4_PW)) begin
      r_nxt.t4_pw = req_i.wdata; // [RQ14]
    end
    if (wr_hit(req_i, timer_pkg::ADDR_CONFIG)) begin
      r_nxt.config_bits = req_i.wdata[1:0];
    end
    if (wr_hit(req_i, timer_pkg::ADDR_MASK)) begin
      r_nxt.mask = req_i.wdata[1:0];
    end

    // Channel 3 counter
    if (!run3) begin
      r_nxt.cnt3 = 8'h00; // [RQ6]
    end else if (match3 || match16) begin
      r_nxt.cnt3 = 8'h00;
    end else if (tick3) begin
      r_nxt.cnt3 = r_r.cnt3 + 8'h01;
    end

    // Channel 4 counter, stepped by channel 3 overflow when cascaded
    if (!run4) begin
      r_nxt.cnt4 = 8'h00; // [RQ6]
    end else if (match4) begin
      r_nxt.cnt4 = 8'h00;
    end else if (step4) begin
      r_nxt.cnt4 = r_r.cnt4 + 8'h01; // [RQ18]
    end

    // Output flip-flops: load on start, toggle on match
    r_nxt.run3_prev = run3;
    r_nxt.run4_prev = run4;
    if (run3 && !r_r.run3_prev) begin
      r_nxt.ff3 = ff3_init; // [RQ12] [RQ9]
    end else if (match3) begin
      r_nxt.ff3 = !r_r.ff3;
    end
    if (run4 && !r_r.run4_prev) begin
      r_nxt.ff4 = r_r.t4_ctl.flipflop_init; // [RQ12]
    end else if (match4) begin
      r_nxt.ff4 = !r_r.ff4;
    end

    // Sticky status: read clears, a new event wins
    r_nxt.status = status_read ? timer_pkg::FLAGS_RESET : r_r.status;
    r_nxt.status[timer_pkg::ST_MATCH3] = r_nxt.status[timer_pkg::ST_MATCH3] | match3;
    r_nxt.status[timer_pkg::ST_MATCH4] = r_nxt.status[timer_pkg::ST_MATCH4] | match4;
    r_nxt.irq = |(r_nxt.status & r_nxt.mask);

    // Read data, valid only in the cycle after the strobe
    r_nxt.rdata = 8'h00;
    if (req_i.rd) begin
      case (req_i.addr)
        timer_pkg::ADDR_T3_CONTROL: r_nxt.rdata = r_r.t3_ctl;
        timer_pkg::ADDR_T3_PERIOD:  r_nxt.rdata = r_r.t3_period;
        timer_pkg::ADDR_T3_PW:      r_nxt.rdata = r_r.t3_pw;
        timer_pkg::ADDR_T4_CONTROL: r_nxt.rdata = r_r.t4_ctl;
        timer_pkg::ADDR_T4_PERIOD:  r_nxt.rdata = r_r.t4_period;
        timer_pkg::ADDR_T4_PW:      r_nxt.rdata = r_r.t4_pw;
        timer_pkg::ADDR_CONFIG:     r_nxt.rdata = {6'h00, r_r.config_bits};
        timer_pkg::ADDR_STATUS:     r_nxt.rdata = {6'h00, r_r.status};
        timer_pkg::ADDR_MASK:       r_nxt.rdata = {6'h00, r_r.mask};
        default:                    r_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      r_r             <= '0;
      r_r.t3_ctl      <= timer_pkg::control_t'(timer_pkg::CONTROL_RESET);
      r_r.t4_ctl      <= timer_pkg::control_t'(timer_pkg::CONTROL_RESET);
      r_r.t3_period   <= timer_pkg::TIMER_RESET;
      r_r.t3_pw       <= timer_pkg::TIMER_RESET;
      r_r.t4_period   <= timer_pkg::TIMER_RESET;
      r_r.t4_pw       <= timer_pkg::TIMER_RESET;
      r_r.config_bits <= timer_pkg::CONFIG_RESET;
      r_r.status      <= timer_pkg::FLAGS_RESET;
      r_r.mask        <= timer_pkg::FLAGS_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs from flip-flops
  assign rdata_o      = r_r.rdata;
  assign timer3_out_o = r_r.ff3;
  assign timer4_out_o = r_r.ff4;
  assign irq_o        = r_r.irq;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence start3_seq;
    run3 && !r_r.run3_prev;
  endsequence

  sequence start4_seq;
    run4 && !r_r.run4_prev;
  endsequence

  chk_t3_period_write: assert property (wr_hit(req_i, timer_pkg::ADDR_T3_PERIOD) // [RQ1]
      |=> (r_r.t3_period == $past(req_i.wdata)))
    else $error("channel 3 period write lost");

  chk_t4_pw_read: assert property ((wr_hit(req_i, timer_pkg::ADDR_T4_PW) ##1 // [RQ14]
      (req_i.rd && req_i.addr == timer_pkg::ADDR_T4_PW && !req_i.wr))
      |=> (rdata_o == $past(req_i.wdata, 2)))
    else $error("channel 4 pulse width readback wrong");

  chk_stop_clears: assert property ((!run3 && !run4) |=> (r_r.cnt3 == 8'h00 && r_r.cnt4 == 8'h00)) // [RQ6]
    else $error("stopped counter not cleared");

  chk_reserved_mode: assert property ((!cascade && r_r.t3_ctl.mode_select[2]) // [RQ7]
      |=> (r_r.cnt3 == 8'h00))
    else $error("reserved mode counted");

  chk_cascade_run: assert property ((cascade && !r_r.t4_ctl.run) |-> !run3) // [RQ9] [RQ8]
    else $error("cascade ignored channel 4 run bit");

  chk_start_level3: assert property (start3_seq |=> (timer3_out_o == $past(ff3_init))) // [RQ12]
    else $error("channel 3 start level wrong");

  chk_start_level4: assert property (start4_seq |=> (timer4_out_o == $past(r_r.t4_ctl.flipflop_init))) // [RQ12]
    else $error("channel 4 start level wrong");

  chk_cascade_source: assert property ((wide16 && run4 && !ovf3 && !match16) // [RQ18]
      |=> $stable(r_r.cnt4))
    else $error("cascaded channel 4 moved without overflow");

  chk_status_sticky: assert property ((match4 && status_read) // [RQ17]
      |=> (r_r.status[timer_pkg::ST_MATCH4] && (irq_o == |(r_r.status & r_r.mask))))
    else $error("match event lost against status read");

endmodule : dual_timer_control
`default_nettype wire

//--- tick_source.sv
`timescale 1ns/1ps
`default_nettype none
module tick_source (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Selection
  input  wire logic [2:0] clock_select_i,
  input  wire logic       slow_mode_i,
  input  wire logic       divider_low_clock_option_i,
  // Synchronised sources
  input  wire logic       low_freq_clock_i,
  input  wire logic       ext_pin_i,
  // Count enable pulse
  output logic            tick_o
);

  timer_pkg::source_state_t r_r;
  timer_pkg::source_state_t r_nxt;
  logic                     low_edge;
  logic                     ext_edge;

  // True when the low bits of the prescaler are all ones
  function automatic logic tap(input logic [10:0] p, input int bits);
    logic [10:0] m;
    m = 11'((32'h1 << bits) - 32'h1);
    return (p & m) == m;
  endfunction : tap

  assign low_edge = low_freq_clock_i & ~r_r.low_prev;
  assign ext_edge = ext_pin_i & ~r_r.ext_prev; // [RQ19]

  // Prescaler, edge history and source mux
  always_comb begin
    r_nxt          = r_r;
    r_nxt.prescale = r_r.prescale + 11'h001;
    r_nxt.low_prev = low_freq_clock_i;
    r_nxt.ext_prev = ext_pin_i;
    if (low_edge) begin
      r_nxt.low_div = r_r.low_div + 3'h1;
    end
    case (clock_select_i) // [RQ4]
      timer_pkg::CK_HIGH_DIV2048: begin
        if (slow_mode_i || divider_low_clock_option_i) begin
          tick_o = low_edge && (r_r.low_div == timer_pkg::LOW_DIV8_LAST); // [RQ5]
        end else begin
          tick_o = tap(r_r.prescale, timer_pkg::DIV2048_BITS);
        end
      end
      timer_pkg::CK_HIGH_DIV128: tick_o = !slow_mode_i && tap(r_r.prescale, timer_pkg::DIV128_BITS);
      timer_pkg::CK_HIGH_DIV32:  tick_o = !slow_mode_i && tap(r_r.prescale, timer_pkg::DIV32_BITS);
      timer_pkg::CK_HIGH_DIV8:   tick_o = !slow_mode_i && tap(r_r.prescale, timer_pkg::DIV8_BITS);
      timer_pkg::CK_LOW:         tick_o = low_edge;
      timer_pkg::CK_HIGH_DIV2:   tick_o = !slow_mode_i && tap(r_r.prescale, timer_pkg::DIV2_BITS);
      timer_pkg::CK_HIGH:        tick_o = 1'b1; // Warm-up use in slow mode [RQ5]
      timer_pkg::CK_PIN:         tick_o = !slow_mode_i && ext_edge; // [RQ19]
      default:                   tick_o = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_high_clock_tick: assert property ((clock_select_i == timer_pkg::CK_HIGH) |-> tick_o) // [RQ4]
    else $error("high clock selection gave no tick");
  chk_slow_invalid: assert property ((slow_mode_i && clock_select_i != timer_pkg::CK_HIGH_DIV2048
      && clock_select_i != timer_pkg::CK_LOW && clock_select_i != timer_pkg::CK_HIGH) |-> !tick_o) // [RQ5]
    else $error("invalid slow-mode source produced a tick");
  chk_pin_edge: assert property ((tick_o && clock_select_i == timer_pkg::CK_PIN)
      |-> (ext_pin_i && !$past(ext_pin_i))) // [RQ19]
    else $error("pin tick without a rising edge");

endmodule : tick_source
`default_nettype wire

//--- timer_pkg.sv
`default_nettype none
package timer_pkg;

  // Register indices on the local port
  localparam logic [3:0] ADDR_T3_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_T3_PERIOD  = 4'h1;
  localparam logic [3:0] ADDR_T3_PW      = 4'h2;
  localparam logic [3:0] ADDR_T4_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_T4_PERIOD  = 4'h4;
  localparam logic [3:0] ADDR_T4_PW      = 4'h5;
  localparam logic [3:0] ADDR_CONFIG     = 4'h6;
  localparam logic [3:0] ADDR_STATUS     = 4'h7;
  localparam logic [3:0] ADDR_MASK       = 4'h8;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] TIMER_RESET   = 8'h00;
  localparam logic [1:0] CONFIG_RESET  = 2'h0;
  localparam logic [1:0] FLAGS_RESET   = 2'h0;

  // Config and status bit positions
  localparam int CFG_DIVIDER_OPT = 0;
  localparam int CFG_SLOW_MODE   = 1;
  localparam int ST_MATCH3       = 0;
  localparam int ST_MATCH4       = 1;

  // Clock-select codes
  localparam logic [2:0] CK_HIGH_DIV2048 = 3'h0;
  localparam logic [2:0] CK_HIGH_DIV128  = 3'h1;
  localparam logic [2:0] CK_HIGH_DIV32   = 3'h2;
  localparam logic [2:0] CK_HIGH_DIV8    = 3'h3;
  localparam logic [2:0] CK_LOW          = 3'h4;
  localparam logic [2:0] CK_HIGH_DIV2    = 3'h5;
  localparam logic [2:0] CK_HIGH         = 3'h6;
  localparam logic [2:0] CK_PIN          = 3'h7;

  // Prescaler tap widths (power-of-two divides)
  localparam int DIV2048_BITS = 11;
  localparam int DIV128_BITS  = 7;
  localparam int DIV32_BITS   = 5;
  localparam int DIV8_BITS    = 3;
  localparam int DIV2_BITS    = 1;
  localparam logic [2:0] LOW_DIV8_LAST = 3'h7;

  // Mode codes
  localparam logic [2:0] MODE_TIMER     = 3'h0;
  localparam logic [2:0] MODE_DIVIDER_OUT = 3'h1;
  localparam logic [2:0] MODE_PWM       = 3'h2;
  localparam logic [2:0] MODE_CASCADE   = 3'h3;
  localparam logic [2:0] MODE16_TIMER   = 3'h4;
  localparam logic [2:0] MODE16_WARMUP  = 3'h5;
  localparam logic [2:0] MODE16_PWM     = 3'h6;
  localparam logic [2:0] MODE16_PULSE_GEN = 3'h7;

  // Control register layout
  typedef struct packed {
    logic       flipflop_init;
    logic [2:0] clock_select;
    logic       run;
    logic [2:0] mode_select;
  } control_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Whole state of the timer pair
  typedef struct packed {
    control_t   t3_ctl;
    control_t   t4_ctl;
    logic [7:0] t3_period;
    logic [7:0] t3_pw;
    logic [7:0] t4_period;
    logic [7:0] t4_pw;
    logic [1:0] config_bits;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] cnt3;
    logic [7:0] cnt4;
    logic       ff3;
    logic       ff4;
    logic       run3_prev;
    logic       run4_prev;
    logic [1:0] sync_low;
    logic [1:0] sync_pin3;
    logic [1:0] sync_pin4;
    logic [7:0] rdata;
    logic       irq;
  } timer_state_t;

  // State of one source selector
  typedef struct packed {
    logic [10:0] prescale;
    logic [2:0]  low_div;
    logic        low_prev;
    logic        ext_prev;
  } source_state_t;

endpackage : timer_pkg
`default_nettype wire
